// ### bench/mosr_pipe_model.sv
// Stand-in for the load/store pipeline and uncore, one op per request
`timescale 1ns/10ps
module mosr_pipe_model (
  // Clock and request
  input wire aclk,
  input wire go,
  // Op report; ls[8] carries the second-level miss, ls[19] the crossing
  output logic op_start,
  output logic [19:0] ls,
  output logic [63:0] lin,
  output logic [63:0] phy,
  // Later events
  output logic dc_fill,
  output logic unc_valid,
  output logic [4:0] unc,
  output logic op_done
);
  logic [2:0] src;
  int step = 0;
  initial {op_start, ls, lin, phy, dc_fill, unc_valid, unc, op_done} = '0;
  // Unqualified fields change every cycle so a late capture shows up
  always @(posedge aclk) begin
    ls <= 20'($urandom | ($urandom & 32'h181));
    lin <= {$urandom, $urandom};
    phy <= {$urandom, $urandom};
    src = 3'(32'h73210 >> (4 * $urandom_range(0, 4)));
    unc <= {1'($urandom), src != 3'h1 && 1'($urandom), src};
    // Stores get fill and uncore pulses too; their results must be dropped
    dc_fill <= step == 3;
    unc_valid <= step == 2;
    op_done <= step == 1;
    op_start <= go && step == 0;
    if (step > 0) step <= step - 1;
    else if (go) step <= 4 + $urandom_range(0, 12);
  end
endmodule // mosr_pipe_model

// ### bench/mosr_props.sv
// Port-level checks for the op sample recorder
`timescale 1ns/10ps
module mosr_props (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Sampling state
  input wire op_done,
  input wire sample_valid,
  input wire sample_busy,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  chk_write_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  chk_sample_commit: assert property (sample_busy && op_done
    |=> sample_valid && !sample_busy) else $error("sample not committed");
  chk_sample_held: assert property (sample_valid && s_axi_wready
    |=> sample_valid) else $error("sample lost");
  chk_one_state: assert property (!(sample_valid && sample_busy))
    else $error("valid and busy together");
endmodule // mosr_props
bind mosr_recorder mosr_props u_props (.*);

// ### bench/test_memory_op_sample_recorder.sv
// Bench for the memory op sample recorder
`timescale 1ns/10ps
`include "mosr_defines.vh"
module test_memory_op_sample_recorder;
  logic aclk = 0, aresetn = 0, go = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, sample_valid, sample_busy;
  wire op_start, dc_fill, unc_valid, op_done;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [19:0] ls;
  wire [63:0] lin, phy;
  wire [4:0] unc;
  logic [33:0] exp_q[$], e;
  logic [19:0] c_ls;
  logic [63:0] c_lin, c_phy;
  logic [15:0] lat;
  logic [4:0] c_unc;
  logic trk = 0, ltrk = 0, ugot = 0;
  int errors = 0, comparisons = 0, cyc = 0;
  always #4 aclk = ~aclk;
  mosr_recorder u_dut (
    .aclk, .aresetn, .clk_en(1'b1), .op_start, .op_load(ls[0]),
    .op_store(ls[1]), .op_lin_valid(ls[17]), .op_lin_addr(lin),
    .op_phy_valid(ls[18]), .op_phy_addr(phy), .dtlb1_miss(ls[2]),
    .dtlb2_miss(ls[3]), .dtlb1_hit_2m(ls[4]), .dtlb1_hit_1g(ls[5]),
    .dtlb2_hit_2m(ls[6]), .dc_miss(ls[7]), .l2_miss(ls[8]),
    .ld_bank_conflict(ls[9]), .st_bank_conflict(ls[10]), .st_fwd(ls[11]),
    .st_fwd_cancel(ls[12]), .uc_access(ls[13]), .wc_access(ls[14]),
    .locked_access(ls[15]), .mab_hit(ls[16]), .op_misalign(ls[19]), .dc_fill,
    .uncore_valid(unc_valid), .uncore_src(unc[2:0]),
    .uncore_remote(unc[3]), .uncore_line_owned(unc[4]), .op_done,
    .sample_valid, .sample_busy, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  mosr_pipe_model u_model (.aclk, .go, .op_start, .ls, .lin, .phy,
    .dc_fill, .unc_valid, .unc, .op_done);
  task automatic cmp_data(input string n, input logic [31:0] x, y);
    comparisons++;
    if (y !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] x, y);
    cmp_data("resp", {30'h0, x}, {30'h0, y});
  endtask
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = 2'h0);
    @(posedge aclk);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_awvalid && !s_axi_awready ||
               s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = 2'h0);
    @(posedge aclk);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    // Late ready lets the held read data be seen standing
    repeat ($urandom_range(0, 1)) @(posedge aclk);
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  task automatic launch;
    go <= 1;
    do @(posedge aclk); while (!op_start);
    go <= 0;
  endtask
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      e = exp_q.pop_front();
      if (s_axi_rvalid) cmp_data("rdata", e[31:0], s_axi_rdata);
      cmp_resp(e[33:32], s_axi_rvalid ? s_axi_rresp : s_axi_bresp);
    end
  end
  // Own view of the op the recorder should hold
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
    if (op_start && !sample_valid && !sample_busy) begin
      {c_ls, c_lin, c_phy, c_unc, lat} <= {ls, lin, phy, 21'h0};
      {trk, ltrk, ugot} <= 3'h6;
    end else if (trk) begin
      if (dc_fill) ltrk <= 0;
      else if (ltrk) lat <= lat + 1;
      if (unc_valid && !ugot) {c_unc, ugot} <= {unc, 1'b1};
      if (op_done) trk <= 0;
    end
  end
  initial begin
    void'($urandom(32'h2e46));
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(`MOSR_CTRL_OFF, 0);
    rd(8'h28, 0, `MOSR_RESP_SLVERR);
    wr(8'h08, 32'h1, `MOSR_RESP_SLVERR);
    launch();
    do @(posedge aclk); while (!op_done);
    rd(`MOSR_CTRL_OFF, 0);
    repeat (60) begin
      wr(`MOSR_CTRL_OFF, 32'h3);
      launch();
      rd(`MOSR_CTRL_OFF, 32'h5);
      do @(posedge aclk); while (!sample_valid);
      launch();
      rd(`MOSR_CTRL_OFF, 32'h3);
      rd(8'h08, {13'h0, c_ls[18:9], c_ls[19], c_ls[7:0]});
      rd(8'h08, {13'h0, c_ls[18:9], c_ls[19], c_ls[7:0]});
      rd(8'h08, {13'h0, c_ls[18:9], c_ls[19], c_ls[7:0]});
      rd(8'h08, {13'h0, c_ls[18:9], c_ls[19], c_ls[7:0]});
      rd(8'h08, {13'h0, c_ls[18:9], c_ls[19], c_ls[7:0]});
      rd(8'h0c, c_ls[0] && c_ls[7] ? {16'h0, lat} : 0);
      rd(8'h10, &{c_ls[0], c_ls[7], c_ls[8]} ?
        {26'h0, c_unc[4:3], 1'b0, c_unc[2:0]} : 0);
      rd(8'h14, 0);
      if (c_ls[17]) rd(8'h18, c_lin[31:0]);
      if (c_ls[17]) rd(8'h1c, c_lin[63:32]);
      if (c_ls[18]) rd(8'h20, c_phy[31:0]);
      if (c_ls[18]) rd(8'h24, c_phy[63:32]);
    end
    give_verdict();
  end
endmodule // test_memory_op_sample_recorder

// ### rtl/mosr_defines.vh
// Register map, field positions and encodings for the op sample recorder
`ifndef MOSR_DEFINES_VH
`define MOSR_DEFINES_VH

// Register byte offsets (AXI4-Lite, one 32-bit word each)
`define MOSR_CTRL_OFF 8'h00
`define MOSR_LSINFO_LO_OFF 8'h08
`define MOSR_LSINFO_HI_OFF 8'h0c
`define MOSR_UNCORE_LO_OFF 8'h10
`define MOSR_UNCORE_HI_OFF 8'h14
`define MOSR_LIN_LO_OFF 8'h18
`define MOSR_LIN_HI_OFF 8'h1c
`define MOSR_PHY_LO_OFF 8'h20
`define MOSR_PHY_HI_OFF 8'h24

// Control register fields
`define MOSR_CTRL_EN_BIT 0
`define MOSR_CTRL_VALID_BIT 1
`define MOSR_CTRL_BUSY_BIT 2

// Load/store info fields (low word)
`define MOSR_LS_LOAD 0
`define MOSR_LS_STORE 1
`define MOSR_LS_DTLB1_MISS 2
`define MOSR_LS_DTLB2_MISS 3
`define MOSR_LS_DTLB1_2M 4
`define MOSR_LS_DTLB1_1G 5
`define MOSR_LS_DTLB2_2M 6
`define MOSR_LS_DC_MISS 7
`define MOSR_LS_MISALIGN 8
`define MOSR_LS_LD_BANK 9
`define MOSR_LS_ST_BANK 10
`define MOSR_LS_FWD 11
`define MOSR_LS_FWD_CAN 12
`define MOSR_LS_UC 13
`define MOSR_LS_WC 14
`define MOSR_LS_LOCKED 15
`define MOSR_LS_MAB_HIT 16
`define MOSR_LS_LIN_VALID 17
`define MOSR_LS_PHY_VALID 18
`define MOSR_LS_FLAG_W 19
// Miss latency sits in the high word, bits [15:0]
`define MOSR_LAT_W 16

// Uncore info fields
`define MOSR_UN_SRC_LSB 0
`define MOSR_UN_REMOTE 4
`define MOSR_UN_LINE_ST 5

// Data source codes
`define MOSR_SRC_NONE 3'h0
`define MOSR_SRC_L3 3'h1
`define MOSR_SRC_CACHE 3'h2
`define MOSR_SRC_DRAM 3'h3
`define MOSR_SRC_IO 3'h7

// AXI responses
`define MOSR_RESP_OKAY 2'h0
`define MOSR_RESP_SLVERR 2'h2

`endif

// ### rtl/mosr_recorder.v
// Memory op sample recorder with AXI4-Lite register slave
// Contract
// - capture linear and physical operand addresses into separate registers
// - linear and physical valid bits set independently per address
// - physical may be valid while linear valid stays clear
// - load and store flags; both set for load-operate-store ops
// - count cycles from data cache miss until fill delivered
// - miss latency meaningful only for loads that missed
// - separate load and store bank conflict flags
// - separate first and second level data TLB miss flags
// - flags for 2M and 1G first TLB hits, 2M second TLB hit
// - data cache miss flag on initial miss
// - misaligned flag when access crosses 128-bit boundary
// - store forward flag and separate forward-cancelled flag
// - flags for uncacheable, write-combining and locked accesses
// - flag when access hit an allocated miss buffer entry
// - uncore info gathered only if enabled and load missed L1 and L2
// - uncore info and latency unreliable for stores; consumers discard
// - remote bit 0 local service, 1 remote service
// - line state bit 0 modified, 1 owned, when source is a cache
// - 3-bit data source code, 4 to 6 reserved
// - source and remote bit decoded together; source 0 invalid
`timescale 1ns/10ps
`include "mosr_defines.vh"

module mosr_recorder (
  // Clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  // Load/store pipeline report of the tagged op
  input wire op_start,
  input wire op_load,
  input wire op_store,
  input wire op_lin_valid,
  input wire [63:0] op_lin_addr,
  input wire op_phy_valid,
  input wire [63:0] op_phy_addr,
  input wire dtlb1_miss,
  input wire dtlb2_miss,
  input wire dtlb1_hit_2m,
  input wire dtlb1_hit_1g,
  input wire dtlb2_hit_2m,
  input wire dc_miss,
  input wire l2_miss,
  input wire ld_bank_conflict,
  input wire st_bank_conflict,
  input wire st_fwd,
  input wire st_fwd_cancel,
  input wire uc_access,
  input wire wc_access,
  input wire locked_access,
  input wire mab_hit,
  input wire op_misalign,
  // Fill delivered to the core for the pending miss
  input wire dc_fill,
  // Uncore response
  input wire uncore_valid,
  input wire [2:0] uncore_src,
  input wire uncore_remote,
  input wire uncore_line_owned,
  // Op completed; sample may be committed
  input wire op_done,
  // Status to the core
  output wire sample_valid,
  output wire sample_busy,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam ST_IDLE = 2'h0;
  localparam ST_TRACK = 2'h1;
  localparam ST_HELD = 2'h2;

  reg [1:0] state_q;
  reg en_q;
  reg [`MOSR_LS_FLAG_W-1:0] flags_w_q;
  reg [`MOSR_LS_FLAG_W-1:0] flags_q;
  reg [63:0] lin_w_q;
  reg [63:0] phy_w_q;
  reg [63:0] lin_q;
  reg [63:0] phy_q;
  reg [`MOSR_LAT_W-1:0] lat_cnt_q;
  reg lat_run_q;
  reg lat_ok_w_q;
  reg [`MOSR_LAT_W-1:0] lat_q;
  reg want_un_q;
  reg [5:0] un_w_q;
  reg [5:0] un_q;
  reg aw_got_q;
  reg w_got_q;
  reg [7:0] aw_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg [`MOSR_LS_FLAG_W-1:0] op_flags;
  reg [31:0] rd_d;
  reg rd_ok;

  wire rearm;
  wire wr_fire;
  wire rd_fire;
  wire [7:0] wa;

  always @* begin
    op_flags = {`MOSR_LS_FLAG_W{1'b0}};
    op_flags[`MOSR_LS_LOAD] = op_load;
    op_flags[`MOSR_LS_STORE] = op_store;
    op_flags[`MOSR_LS_DTLB1_MISS] = dtlb1_miss;
    op_flags[`MOSR_LS_DTLB2_MISS] = dtlb2_miss;
    op_flags[`MOSR_LS_DTLB1_2M] = dtlb1_hit_2m;
    op_flags[`MOSR_LS_DTLB1_1G] = dtlb1_hit_1g;
    op_flags[`MOSR_LS_DTLB2_2M] = dtlb2_hit_2m;
    op_flags[`MOSR_LS_DC_MISS] = dc_miss;
    // Access size is only known upstream, so the 128-bit crossing comes in
    op_flags[`MOSR_LS_MISALIGN] = op_misalign;
    op_flags[`MOSR_LS_LD_BANK] = ld_bank_conflict;
    op_flags[`MOSR_LS_ST_BANK] = st_bank_conflict;
    op_flags[`MOSR_LS_FWD] = st_fwd;
    op_flags[`MOSR_LS_FWD_CAN] = st_fwd_cancel;
    op_flags[`MOSR_LS_UC] = uc_access;
    op_flags[`MOSR_LS_WC] = wc_access;
    op_flags[`MOSR_LS_LOCKED] = locked_access;
    op_flags[`MOSR_LS_MAB_HIT] = mab_hit;
    op_flags[`MOSR_LS_LIN_VALID] = op_lin_valid;
    op_flags[`MOSR_LS_PHY_VALID] = op_phy_valid;
  end

  // Sample tracking: working copy fills while the op is in flight,
  // then is copied as one unit so software never sees a half sample
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      flags_w_q <= {`MOSR_LS_FLAG_W{1'b0}};
      flags_q <= {`MOSR_LS_FLAG_W{1'b0}};
      lin_w_q <= 64'h0;
      phy_w_q <= 64'h0;
      lin_q <= 64'h0;
      phy_q <= 64'h0;
      lat_cnt_q <= {`MOSR_LAT_W{1'b0}};
      lat_run_q <= 1'b0;
      lat_ok_w_q <= 1'b0;
      lat_q <= {`MOSR_LAT_W{1'b0}};
      want_un_q <= 1'b0;
      un_w_q <= 6'h0;
      un_q <= 6'h0;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          if (en_q && op_start) begin
            state_q <= ST_TRACK;
            flags_w_q <= op_flags;
            // Addresses stored as given; valid bits qualify them
            lin_w_q <= op_lin_addr;
            phy_w_q <= op_phy_addr;
            lat_cnt_q <= {`MOSR_LAT_W{1'b0}};
            lat_run_q <= op_load & dc_miss;
            lat_ok_w_q <= 1'b0;
            want_un_q <= op_load & dc_miss & l2_miss;
            un_w_q <= 6'h0;
          end
        end
        ST_TRACK: begin
          if (lat_run_q) begin
            if (dc_fill) begin
              lat_run_q <= 1'b0;
              lat_ok_w_q <= 1'b1;
            end else if (lat_cnt_q != {`MOSR_LAT_W{1'b1}}) begin
              // Saturates rather than wrapping on very long misses
              lat_cnt_q <= lat_cnt_q +
                           {{(`MOSR_LAT_W-1){1'b0}}, 1'b1};
            end
          end
          if (want_un_q && uncore_valid) begin
            want_un_q <= 1'b0;
            // Codes pass through; 0 already reads as invalid
            un_w_q <= {uncore_line_owned, uncore_remote, 1'b0,
                       uncore_src};
          end
          if (op_done) begin
            state_q <= ST_HELD;
            flags_q <= flags_w_q;
            lin_q <= lin_w_q;
            phy_q <= phy_w_q;
            // Stores keep latency at zero; value is load-only
            lat_q <= (lat_ok_w_q && flags_w_q[`MOSR_LS_LOAD]) ?
                     lat_cnt_q : {`MOSR_LAT_W{1'b0}};
            un_q <= un_w_q;
          end
        end
        ST_HELD: begin
          if (rearm) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign sample_valid = (state_q == ST_HELD);
  assign sample_busy = (state_q == ST_TRACK);

  // AXI4-Lite write path: address and data latched independently
  // Readies drop with the enable so no beat is lost while frozen
  assign s_axi_awready = clk_en && !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = clk_en && !w_got_q && !s_axi_bvalid;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wa = aw_q;
  // Writing 1 to the valid bit releases the held sample
  assign rearm = wr_fire && (wa == `MOSR_CTRL_OFF) && ws_q[0] &&
                 wd_q[`MOSR_CTRL_VALID_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_q <= 8'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MOSR_RESP_OKAY;
      en_q <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wa == `MOSR_CTRL_OFF) begin
          s_axi_bresp <= `MOSR_RESP_OKAY;
          if (ws_q[0]) begin
            en_q <= wd_q[`MOSR_CTRL_EN_BIT];
          end
        end else begin
          // Capture registers are read-only
          s_axi_bresp <= `MOSR_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always @* begin
    rd_d = 32'h0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `MOSR_CTRL_OFF: begin
        rd_d[`MOSR_CTRL_EN_BIT] = en_q;
        rd_d[`MOSR_CTRL_VALID_BIT] = sample_valid;
        rd_d[`MOSR_CTRL_BUSY_BIT] = sample_busy;
      end
      `MOSR_LSINFO_LO_OFF: rd_d[`MOSR_LS_FLAG_W-1:0] = flags_q;
      `MOSR_LSINFO_HI_OFF: rd_d[`MOSR_LAT_W-1:0] = lat_q;
      `MOSR_UNCORE_LO_OFF: rd_d[5:0] = un_q;
      `MOSR_UNCORE_HI_OFF: rd_d = 32'h0;
      `MOSR_LIN_LO_OFF: rd_d = lin_q[31:0];
      `MOSR_LIN_HI_OFF: rd_d = lin_q[63:32];
      `MOSR_PHY_LO_OFF: rd_d = phy_q[31:0];
      `MOSR_PHY_HI_OFF: rd_d = phy_q[63:32];
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `MOSR_RESP_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_ok ? `MOSR_RESP_OKAY : `MOSR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // mosr_recorder
